// ### core/doc_pkg.sv
// Package holding the constants of the configurable digital output block.
`default_nettype none
package doc_pkg;
    localparam int N_LOCAL = 8;
    localparam int N_EXP   = 16;
    localparam int N_OUT   = N_LOCAL + 2 * N_EXP;
    localparam int FN_W    = 4;

    // Clock and the millisecond time base used by all timing registers.
    localparam int CLK_MHZ      = 250;
    localparam int TICK_TIME_US = 1000;
    localparam int TICK_CYCLES  = CLK_MHZ * TICK_TIME_US;
    localparam logic [15:0] PULSE_MS = 16'h00C8;

    // Register byte offsets.
    localparam logic [11:0] OFS_LOCAL_MASK = 12'h000;
    localparam logic [11:0] OFS_EXPA_MASK  = 12'h004;
    localparam logic [11:0] OFS_EXPB_MASK  = 12'h008;
    localparam logic [11:0] OFS_XFER_MS    = 12'h00C;
    localparam logic [11:0] OFS_PAUSE_MS   = 12'h010;
    localparam logic [11:0] OFS_LOCAL_STAT = 12'h014;
    localparam logic [11:0] OFS_EXPA_STAT  = 12'h018;
    localparam logic [11:0] OFS_EXPB_STAT  = 12'h01C;
    localparam logic [11:0] OFS_CO_STAT    = 12'h020;
    localparam logic [11:0] OFS_FSEL_BASE  = 12'h040;

    // Reset values.
    localparam logic [7:0]  RST_LOCAL_MASK = 8'h00;
    localparam logic [15:0] RST_EXP_MASK   = 16'h0000;
    localparam logic [15:0] RST_XFER_MS    = 16'h0000;
    localparam logic [15:0] RST_PAUSE_MS   = 16'h0000;

    // Function codes selectable on any output.
    localparam logic [FN_W-1:0] FN_UNASSIGNED      = 4'h0;
    localparam logic [FN_W-1:0] FN_SERIAL          = 4'h1;
    localparam logic [FN_W-1:0] FN_LOGIC           = 4'h2;
    localparam logic [FN_W-1:0] FN_ENERGIZED_STOP  = 4'h3;
    localparam logic [FN_W-1:0] FN_HORN            = 4'h4;
    localparam logic [FN_W-1:0] FN_STARTER         = 4'h5;
    localparam logic [FN_W-1:0] FN_FUEL            = 4'h6;
    localparam logic [FN_W-1:0] FN_MAINS_HOLD_OPEN = 4'h7;
    localparam logic [FN_W-1:0] FN_GEN_HOLD_CLOSED = 4'h8;
    localparam logic [FN_W-1:0] FN_GEN_PULSE_OPEN  = 4'h9;
    localparam logic [FN_W-1:0] FN_GEN_PULSE_CLOSE = 4'hA;

    // Built-in output positions.
    localparam int POS_AUX1  = 0;
    localparam int POS_AUX2  = 1;
    localparam int POS_STARTER = 4;
    localparam int POS_FUEL  = 5;
    localparam int POS_MAINS = 6;
    localparam int POS_GEN   = 7;

    typedef enum logic [1:0] {
        CO_MAINS,
        CO_PAUSE_TO_GEN,
        CO_GEN,
        CO_PAUSE_TO_MAINS
    } doc_co_state_t;
endpackage : doc_pkg
`default_nettype wire

// ### core/doc_top.sv
// Configurable digital output stage with APB register access and change-over control.
//
// Added by the designer: the APB interface to the registers and the address map.
`default_nettype none
module doc_top #(
    parameter int TICK_CYCLES = doc_pkg::TICK_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        large_variant,
    input  wire logic [15:0] seq_req,
    input  wire logic [39:0] serial_cmd,
    input  wire logic [39:0] logic_result,
    input  wire logic        load_to_gen,
    input  wire logic        sources_synced,
    output logic      [7:0]  local_out,
    output logic      [15:0] exp_a_out,
    output logic      [15:0] exp_b_out
);
    localparam int NO = doc_pkg::N_OUT;

    logic        rs1_q;
    logic        rs2_q;
    logic        rsn;
    logic        init_done_q;
    logic        large_q;
    logic [7:0]  local_mask_q;
    logic [15:0] expa_mask_q;
    logic [15:0] expb_mask_q;
    logic [15:0] xfer_ms_q;
    logic [15:0] pause_ms_q;
    logic [doc_pkg::FN_W-1:0] fsel_q [NO];
    logic [NO-1:0] out_q;
    logic [NO-1:0] req;
    logic [NO-1:0] mask;
    logic [15:0] func_req;
    logic [31:0] rdata_d;
    logic        rerr_d;
    logic        setup;
    logic        wr_en;
    logic [31:0] tick_cnt_q;
    logic        tick;
    doc_pkg::doc_co_state_t co_q;
    logic [15:0] xfer_cnt_q;
    logic [15:0] pause_cnt_q;
    logic [15:0] open_pulse_q;
    logic [15:0] close_pulse_q;
    logic        xfer_done;

    // Reset is released through two flip-flops so every register behind them leaves reset together.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rs1_q <= 1'b0;
            rs2_q <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rs2_q <= rs1_q;
        end
    end
    assign rsn = rs2_q;

    function automatic logic fsel_hit(input logic [11:0] a);
        fsel_hit = (a >= doc_pkg::OFS_FSEL_BASE) && (a[1:0] == 2'b00)
                && (a < doc_pkg::OFS_FSEL_BASE + 12'(4 * NO));
    endfunction : fsel_hit

    function automatic int fsel_idx(input logic [11:0] a);
        fsel_idx = int'((a - doc_pkg::OFS_FSEL_BASE) >> 2);
    endfunction : fsel_idx

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite;

    // The variant strap is sampled once, right after reset release, never inside reset.
    always_ff @(posedge clk or negedge rsn) begin
        if (!rsn) begin
            init_done_q <= 1'b0;
            large_q     <= 1'b0;
        end else if (!init_done_q) begin
            init_done_q <= 1'b1;
            large_q     <= large_variant;
        end
    end

    // Polarity masks and change-over timing registers.
    always_ff @(posedge clk or negedge rsn) begin
        if (!rsn) begin
            local_mask_q <= doc_pkg::RST_LOCAL_MASK;
            expa_mask_q  <= doc_pkg::RST_EXP_MASK;
            expb_mask_q  <= doc_pkg::RST_EXP_MASK;
            xfer_ms_q    <= doc_pkg::RST_XFER_MS;
            pause_ms_q   <= doc_pkg::RST_PAUSE_MS;
        end else if (wr_en) begin
            unique case (paddr)
                doc_pkg::OFS_LOCAL_MASK: local_mask_q <= pwdata[7:0];
                doc_pkg::OFS_EXPA_MASK:  expa_mask_q  <= pwdata[15:0];
                doc_pkg::OFS_EXPB_MASK:  expb_mask_q  <= pwdata[15:0];
                doc_pkg::OFS_XFER_MS:    xfer_ms_q    <= pwdata[15:0];
                doc_pkg::OFS_PAUSE_MS:   pause_ms_q   <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // Function selections; relay defaults follow the strap, loaded in the first cycle.
    always_ff @(posedge clk or negedge rsn) begin
        if (!rsn) begin
            for (int i = 0; i < NO; i++) begin
                fsel_q[i] <= doc_pkg::FN_UNASSIGNED;
            end
        end else if (!init_done_q) begin
            fsel_q[doc_pkg::POS_AUX1]    <= doc_pkg::FN_ENERGIZED_STOP;
            fsel_q[doc_pkg::POS_AUX2]    <= doc_pkg::FN_HORN;
            fsel_q[doc_pkg::POS_STARTER] <= doc_pkg::FN_STARTER;
            fsel_q[doc_pkg::POS_FUEL]    <= doc_pkg::FN_FUEL;
            if (large_variant) begin
                fsel_q[doc_pkg::POS_MAINS] <= doc_pkg::FN_GEN_PULSE_OPEN;
                fsel_q[doc_pkg::POS_GEN]   <= doc_pkg::FN_GEN_PULSE_CLOSE;
            end else begin
                fsel_q[doc_pkg::POS_MAINS] <= doc_pkg::FN_MAINS_HOLD_OPEN;
                fsel_q[doc_pkg::POS_GEN]   <= doc_pkg::FN_GEN_HOLD_CLOSED;
            end
        end else if (wr_en && fsel_hit(paddr)) begin
            fsel_q[fsel_idx(paddr)] <= pwdata[doc_pkg::FN_W-1:0];
        end
    end

    // Millisecond time base shared by transfer, pause and pulse timers.
    always_ff @(posedge clk or negedge rsn) begin
        if (!rsn) begin
            tick_cnt_q <= 32'h0000_0000;
        end else if (tick_cnt_q == 32'(TICK_CYCLES - 1)) begin
            tick_cnt_q <= 32'h0000_0000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
        end
    end
    assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));

    assign xfer_done = (xfer_cnt_q == 16'h0000);

    // Change-over sequencer. Breakers are only ever closed one at a time, so the
    // synchronized-overlap case is never needed; the sync input only shortens the pause.
    always_ff @(posedge clk or negedge rsn) begin
        if (!rsn) begin
            co_q        <= doc_pkg::CO_MAINS;
            xfer_cnt_q  <= 16'h0000;
            pause_cnt_q <= 16'h0000;
        end else begin
            if (!xfer_done && tick) begin
                xfer_cnt_q <= xfer_cnt_q - 16'h0001;
            end
            if (pause_cnt_q != 16'h0000 && tick) begin
                pause_cnt_q <= pause_cnt_q - 16'h0001;
            end
            unique case (co_q)
                doc_pkg::CO_MAINS: begin
                    if (load_to_gen && xfer_done) begin
                        co_q        <= doc_pkg::CO_PAUSE_TO_GEN;
                        xfer_cnt_q  <= xfer_ms_q;
                        pause_cnt_q <= pause_ms_q;
                    end
                end
                doc_pkg::CO_PAUSE_TO_GEN: begin
                    if (pause_cnt_q == 16'h0000 || sources_synced) begin
                        co_q <= doc_pkg::CO_GEN;
                    end
                end
                doc_pkg::CO_GEN: begin
                    if (!load_to_gen && xfer_done) begin
                        co_q        <= doc_pkg::CO_PAUSE_TO_MAINS;
                        xfer_cnt_q  <= xfer_ms_q;
                        pause_cnt_q <= pause_ms_q;
                    end
                end
                doc_pkg::CO_PAUSE_TO_MAINS: begin
                    if (pause_cnt_q == 16'h0000 || sources_synced) begin
                        co_q <= doc_pkg::CO_MAINS;
                    end
                end
            endcase
        end
    end

    // Pulsed breaker coils fire on entry to and exit from the generator state.
    always_ff @(posedge clk or negedge rsn) begin
        if (!rsn) begin
            open_pulse_q  <= 16'h0000;
            close_pulse_q <= 16'h0000;
        end else begin
            if (co_q == doc_pkg::CO_PAUSE_TO_GEN
                    && (pause_cnt_q == 16'h0000 || sources_synced)) begin
                close_pulse_q <= doc_pkg::PULSE_MS;
            end else if (close_pulse_q != 16'h0000 && tick) begin
                close_pulse_q <= close_pulse_q - 16'h0001;
            end
            if (co_q == doc_pkg::CO_GEN && !load_to_gen && xfer_done) begin
                open_pulse_q <= doc_pkg::PULSE_MS;
            end else if (open_pulse_q != 16'h0000 && tick) begin
                open_pulse_q <= open_pulse_q - 16'h0001;
            end
        end
    end

    // Requests of every function code; change-over codes come from the sequencer above.
    always_comb begin
        func_req = seq_req;
        func_req[doc_pkg::FN_UNASSIGNED]      = 1'b0;
        func_req[doc_pkg::FN_SERIAL]          = 1'b0;
        func_req[doc_pkg::FN_LOGIC]           = 1'b0;
        func_req[doc_pkg::FN_MAINS_HOLD_OPEN] = (co_q != doc_pkg::CO_MAINS);
        func_req[doc_pkg::FN_GEN_HOLD_CLOSED] = (co_q == doc_pkg::CO_GEN);
        func_req[doc_pkg::FN_GEN_PULSE_OPEN]  = (open_pulse_q != 16'h0000);
        func_req[doc_pkg::FN_GEN_PULSE_CLOSE] = (close_pulse_q != 16'h0000);
    end

    assign mask = {expb_mask_q, expa_mask_q, local_mask_q};

    genvar g;
    generate
        for (g = 0; g < NO; g++) begin : g_sel
            always_comb begin
                unique case (fsel_q[g])
                    doc_pkg::FN_SERIAL: req[g] = serial_cmd[g];
                    doc_pkg::FN_LOGIC:  req[g] = logic_result[g];
                    default:            req[g] = func_req[fsel_q[g]];
                endcase
            end
        end
    endgenerate

    // Registered outputs; out_q is cleared in reset, so every pin rests inactive.
    always_ff @(posedge clk or negedge rsn) begin
        if (!rsn) begin
            out_q <= 40'h00_0000_0000;
        end else begin
            out_q <= req ^ mask;
        end
    end

    assign local_out = out_q[7:0];
    assign exp_a_out = out_q[23:8];
    assign exp_b_out = out_q[39:24];

    // Read data is captured in the setup phase so the access phase needs no wait.
    always_comb begin
        rdata_d = 32'h0000_0000;
        rerr_d  = 1'b0;
        if (fsel_hit(paddr)) begin
            rdata_d[doc_pkg::FN_W-1:0] = fsel_q[fsel_idx(paddr)];
        end else begin
            unique case (paddr)
                doc_pkg::OFS_LOCAL_MASK: rdata_d[7:0]  = local_mask_q;
                doc_pkg::OFS_EXPA_MASK:  rdata_d[15:0] = expa_mask_q;
                doc_pkg::OFS_EXPB_MASK:  rdata_d[15:0] = expb_mask_q;
                doc_pkg::OFS_XFER_MS:    rdata_d[15:0] = xfer_ms_q;
                doc_pkg::OFS_PAUSE_MS:   rdata_d[15:0] = pause_ms_q;
                doc_pkg::OFS_LOCAL_STAT: rdata_d[7:0]  = out_q[7:0];
                doc_pkg::OFS_EXPA_STAT:  rdata_d[15:0] = out_q[23:8];
                doc_pkg::OFS_EXPB_STAT:  rdata_d[15:0] = out_q[39:24];
                doc_pkg::OFS_CO_STAT:    rdata_d[3:0]  = {large_q, xfer_done, co_q};
                default:                 rerr_d = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rsn) begin
        if (!rsn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? 32'h0000_0000 : rdata_d;
            pslverr <= rerr_d;
        end
    end

    assign pready = psel && penable;
endmodule : doc_top
`default_nettype wire

// ### sim/doc_monitor.sv
// Checker on the ports of the configurable digital output block.
`default_nettype none
module doc_monitor (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        large_variant,
    input wire logic [7:0]  local_out,
    input wire logic [15:0] exp_a_out,
    input wire logic [15:0] exp_b_out
);
    logic acc;
    logic dflt_q;
    assign acc = psel && penable;
    // Relay checks are only meaningful while the relays keep their power-up selection.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dflt_q <= 1'b1;
        end else if (acc && pwrite && (paddr == doc_pkg::OFS_LOCAL_MASK
                     || paddr == doc_pkg::OFS_FSEL_BASE + 12'h018
                     || paddr == doc_pkg::OFS_FSEL_BASE + 12'h01C)) begin
            dflt_q <= 1'b0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    reset_outputs_a: assert property (disable iff (1'b0)
        !rst_n |-> {local_out, exp_a_out, exp_b_out} == 40'h0) else $error("Outputs set in reset.");
    ready_follows_a: assert property (pready == acc) else $error("Ready not in access.");
    write_data_a: assert property (acc && pwrite |-> prdata == 32'h0) else $error("Write data.");
    local_width_a: assert property (acc && paddr == doc_pkg::OFS_LOCAL_MASK
        |-> prdata[31:8] == 24'h0) else $error("Local mask too wide.");
    exp_width_a: assert property (acc && (paddr == doc_pkg::OFS_EXPA_MASK
        || paddr == doc_pkg::OFS_EXPB_MASK) |-> prdata[31:16] == 16'h0) else $error("Wide.");
    slave_error_a: assert property (acc && (paddr == 12'h024 || paddr == 12'h000)
        |-> pslverr == (paddr == 12'h024)) else $error("Error flag wrong.");
    status_bits_a: assert property (psel && !penable && !pwrite
        && paddr == doc_pkg::OFS_LOCAL_STAT |=> prdata[7:0] == $past(local_out))
        else $error("Status differs from outputs.");
    no_overlap_a: assert property (dflt_q && !large_variant
        |-> !(local_out[7] && !local_out[6])) else $error("Both breakers closed.");
    open_first_a: assert property (dflt_q && !large_variant && $rose(local_out[7])
        |-> $past(local_out[6])) else $error("Closed before opening.");
endmodule : doc_monitor
`default_nettype wire

// ### sim/doc_load_model.sv
// Behavioural relays and breakers on the change-over outputs.
`default_nettype none
module doc_load_model (
    input  wire logic clk,
    input  wire logic pulsed,
    input  wire logic gen_cmd,
    input  wire logic mains_cmd,
    output logic      gen_closed,
    output logic      mains_closed
);
    // Pulsed coils latch the breaker, so a missed pulse leaves it where it was.
    always_ff @(posedge clk) begin
        if (!pulsed) begin
            gen_closed <= gen_cmd;
        end else if (gen_cmd) begin
            gen_closed <= 1'b1;
        end else if (mains_cmd) begin
            gen_closed <= 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        mains_closed <= !pulsed && !mains_cmd;
    end
endmodule : doc_load_model
`default_nettype wire

// ### sim/doc_top_tb.sv
// Self-checking bench for the configurable digital output block.
`default_nettype none
module doc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 10;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic        large_variant, load_to_gen, sources_synced, gen_closed, mains_closed;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] seq_req, exp_a_out, exp_b_out;
    logic [39:0] serial_cmd, logic_result, outs;
    logic [7:0]  local_out;
    int          bad_count, cmp_count;
    assign outs = {exp_b_out, exp_a_out, local_out};
    doc_top #(.TICK_CYCLES(TK)) dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .large_variant, .seq_req, .serial_cmd, .logic_result,
        .load_to_gen, .sources_synced, .local_out, .exp_a_out, .exp_b_out);
    doc_load_model model (.clk, .pulsed(large_variant), .gen_cmd(local_out[7]),
        .mains_cmd(local_out[6]), .gen_closed, .mains_closed);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk({7'h0, e, r}, {7'h0, xe, x});
    endtask : rd
    task automatic settle;
        repeat (2) @(posedge clk);
    endtask : settle
    task automatic wait_lvl(input int i, input logic v, output int n);
        n = 0;
        while (outs[i] !== v && n < 5000) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_lvl
    task automatic do_reset(input logic big);
        @(posedge clk);
        rst_n <= 1'b0;
        large_variant <= big;
        load_to_gen <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : do_reset
    task automatic s_defaults;
        rd(doc_pkg::OFS_LOCAL_MASK, 32'h0, 1'b0);
        rd(doc_pkg::OFS_EXPA_MASK, 32'h0, 1'b0);
        rd(doc_pkg::OFS_EXPB_MASK, 32'h0, 1'b0);
        rd(doc_pkg::OFS_FSEL_BASE, {28'h0, doc_pkg::FN_ENERGIZED_STOP}, 1'b0);
        rd(doc_pkg::OFS_FSEL_BASE + 12'h004, {28'h0, doc_pkg::FN_HORN}, 1'b0);
        rd(12'h024, 32'h0, 1'b1);
        seq_req <= 16'h0078;
        settle;
        chk(outs, 40'h33);
        seq_req <= 16'h0;
    endtask : s_defaults
    task automatic s_changeover;
        int n;
        int m;
        wr(doc_pkg::OFS_PAUSE_MS, 32'h3);
        load_to_gen <= 1'b1;
        wait_lvl(6, 1'b1, n);
        wait_lvl(7, 1'b1, m);
        chk({39'h0, m > 2 * TK && m <= 3 * TK + 3}, 40'h1);
        settle;
        chk({38'h0, gen_closed, mains_closed}, 40'h2);
        sources_synced <= 1'b1;
        load_to_gen <= 1'b0;
        wait_lvl(7, 1'b0, n);
        wait_lvl(6, 1'b0, m);
        chk({39'h0, m < 3}, 40'h1);
        sources_synced <= 1'b0;
        wr(doc_pkg::OFS_PAUSE_MS, 32'h0);
        wr(doc_pkg::OFS_XFER_MS, 32'h5);
        load_to_gen <= 1'b1;
        wait_lvl(7, 1'b1, n);
        load_to_gen <= 1'b0;
        wait_lvl(7, 1'b0, m);
        chk({39'h0, n + m > 4 * TK && n + m < 7 * TK}, 40'h1);
    endtask : s_changeover
    task automatic s_pulsed;
        int n;
        int m;
        do_reset(1'b1);
        load_to_gen <= 1'b1;
        wait_lvl(7, 1'b1, n);
        wait_lvl(7, 1'b0, m);
        chk({39'h0, m >= 199 * TK && m <= 201 * TK}, 40'h1);
        chk({39'h0, gen_closed}, 40'h1);
        load_to_gen <= 1'b0;
        wait_lvl(6, 1'b1, n);
        settle;
        chk({39'h0, gen_closed}, 40'h0);
        rd(doc_pkg::OFS_CO_STAT, 32'hC, 1'b0);
    endtask : s_pulsed
    task automatic s_route(input logic [3:0] fn, input logic [39:0] pat);
        logic [39:0] x;
        x = pat ^ 40'h0420_8001_81;
        for (int i = 0; i < 40; i++) wr(doc_pkg::OFS_FSEL_BASE + 12'(4 * i), {28'h0, fn});
        serial_cmd <= (fn == doc_pkg::FN_SERIAL) ? pat : ~pat;
        logic_result <= (fn == doc_pkg::FN_LOGIC) ? pat : ~pat;
        seq_req <= 16'hFFFF;
        wr(doc_pkg::OFS_LOCAL_MASK, 32'hFFFF_FF81);
        wr(doc_pkg::OFS_EXPA_MASK, 32'hFFFF_8001);
        wr(doc_pkg::OFS_EXPB_MASK, 32'hFFFF_0420);
        settle;
        chk(outs, x);
        rd(doc_pkg::OFS_LOCAL_MASK, 32'h81, 1'b0);
        rd(doc_pkg::OFS_EXPB_MASK, 32'h0420, 1'b0);
        rd(doc_pkg::OFS_LOCAL_STAT, {24'h0, x[7:0]}, 1'b0);
        rd(doc_pkg::OFS_EXPA_STAT, {16'h0, x[23:8]}, 1'b0);
    endtask : s_route
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude
    initial begin
        {rst_n, psel, penable, pwrite, large_variant, load_to_gen, sources_synced} = 7'h0;
        {paddr, pwdata, seq_req, serial_cmd, logic_result} = 140'h0;
        bad_count = 0;
        cmp_count = 0;
        do_reset(1'b0);
        s_defaults;
        s_changeover;
        s_pulsed;
        s_route(doc_pkg::FN_SERIAL, 40'h80_1234_8001);
        s_route(doc_pkg::FN_LOGIC, 40'h3C_A5F0_0F69);
        conclude;
    end
    // The pulsed change-over dominates the run at about two thousand cycles.
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        conclude;
    end
endmodule : doc_top_tb
bind doc_top doc_monitor u_mon (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .prdata,
    .pready, .pslverr, .large_variant, .local_out, .exp_a_out, .exp_b_out);
`default_nettype wire
